// ### dv/tb_top.sv
// Purpose: Self-checking bench for the increment and branch execute block
// Assumes: Results show just after the edge that takes an instruction
// Notes:   Register read data is driven per instruction by the bench
`timescale 1ns/1ps
module tb_top;
  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic                instr_valid_in = 1'b0;
  mib_pkg::mib_instr_t instr_in = '0;
  logic [7:0]          reg_rdata_in = 8'h00;
  logic [7:0]          table_high_pointer_in = 8'h00;
  logic [6:0]          reg_raddr_out;
  mib_pkg::mib_wr_t    reg_wr_out;
  logic [7:0]          accumulator_out;
  logic [10:0]         program_counter_out;
  logic                global_interrupt_enable_out;
  logic                zero_flag_out;
  logic                ready_out;
  logic                discard_out;
  int                  failures = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  logic [10:0]         exp_pc = 11'h000;

  always #20 clk_in = ~clk_in;

  mib_core uut (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .reg_rdata_in(reg_rdata_in), .table_high_pointer_in(table_high_pointer_in), .reg_raddr_out(reg_raddr_out),
    .reg_wr_out(reg_wr_out), .accumulator_out(accumulator_out), .program_counter_out(program_counter_out),
    .global_interrupt_enable_out(global_interrupt_enable_out), .zero_flag_out(zero_flag_out),
    .ready_out(ready_out), .discard_out(discard_out));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Cuts a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Presents one instruction, lets it be taken, then settles
  task automatic issue(input logic [2:0] op, input logic [6:0] addr, input logic dest, input logic [7:0] rd);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= '{op: op, addr: addr, dest: dest};
    reg_rdata_in   <= rd;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1;
    exp_pc = exp_pc + 11'h001;
  endtask : issue

  task automatic t_int_on();
    chk("pc_rst", 11'h000, program_counter_out);
    chk("ready_rst", 1'b1, ready_out);
    issue(mib_pkg::OP_INT_ON, 7'h00, 1'b0, 8'h00);
    chk("gie", 1'b1, global_interrupt_enable_out);
    chk("zero", 1'b0, zero_flag_out);
    chk("pc", exp_pc, program_counter_out);
    $display("test int enable done");
  endtask : t_int_on

  task automatic t_inc();
    issue(mib_pkg::OP_INC, 7'h7f, mib_pkg::DEST_REG, 8'hff);
    chk("raddr", 7'h7f, reg_raddr_out);
    chk("wr", {1'b1, 7'h7f, 8'h00}, reg_wr_out);
    chk("zero", 1'b1, zero_flag_out);
    chk("accum", 8'h00, accumulator_out);
    issue(mib_pkg::OP_INC, 7'h05, mib_pkg::DEST_ACCUM, 8'h41);
    chk("accum", 8'h42, accumulator_out);
    chk("wr_en", 1'b0, reg_wr_out.en);
    chk("zero", 1'b0, zero_flag_out);
    chk("pc", exp_pc, program_counter_out);
    $display("test inc done");
  endtask : t_inc

  task automatic t_skip();
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= '{op: mib_pkg::OP_INCSZ, addr: 7'h12, dest: mib_pkg::DEST_REG};
    reg_rdata_in   <= 8'hff;
    @(posedge clk_in);
    // The already fetched next instruction stands during the skip cycle
    instr_in       <= '{op: mib_pkg::OP_INC, addr: 7'h13, dest: mib_pkg::DEST_ACCUM};
    reg_rdata_in   <= 8'h77;
    #1;
    exp_pc = exp_pc + 11'h001;
    chk("wr", {1'b1, 7'h12, 8'h00}, reg_wr_out);
    chk("discard", 1'b1, discard_out);
    chk("ready", 1'b0, ready_out);
    chk("zero", 1'b0, zero_flag_out);
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1;
    exp_pc = exp_pc + 11'h001;
    chk("accum_kept", 8'h42, accumulator_out);
    chk("wr_en_kept", 1'b0, reg_wr_out.en);
    chk("discard2", 1'b0, discard_out);
    chk("ready2", 1'b1, ready_out);
    chk("pc", exp_pc, program_counter_out);
    issue(mib_pkg::OP_INC, 7'h01, mib_pkg::DEST_REG, 8'hff);
    issue(mib_pkg::OP_INCSZ, 7'h0a, mib_pkg::DEST_ACCUM, 8'h33);
    chk("accum", 8'h34, accumulator_out);
    chk("discard", 1'b0, discard_out);
    chk("ready", 1'b1, ready_out);
    chk("zero", 1'b1, zero_flag_out);
    chk("pc", exp_pc, program_counter_out);
    $display("test skip done");
  endtask : t_skip

  task automatic t_jump();
    @(posedge clk_in);
    table_high_pointer_in <= 8'hfa;
    issue(mib_pkg::OP_JUMP, 7'h00, 1'b0, 8'h00);
    chk("pc", 11'h234, program_counter_out);
    chk("accum_jump", 8'h34, accumulator_out);
    chk("wr_en_jump", 1'b0, reg_wr_out.en);
    chk("ready", 1'b0, ready_out);
    chk("zero", 1'b1, zero_flag_out);
    @(posedge clk_in);
    #1;
    chk("ready2", 1'b1, ready_out);
    chk("pc2", 11'h234, program_counter_out);
    $display("test jump done");
  endtask : t_jump

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    t_int_on();
    t_inc();
    t_skip();
    t_jump();
    conclude();
  end
endmodule : tb_top

// ### hdl/mib_core.sv
// Purpose: Execute stage for interrupt enable, increments and computed jump
// Assumes: Register file read data valid combinationally for the presented address
// Notes:   Instruction accepted when ready_out is high and instr_valid_in is high
`timescale 1ns/1ps
// How it works
// - Enable-interrupts sets the global enable bit, one cycle, no flags touched.
// - Increment adds one; destination 0 writes accumulator, 1 writes register.
// - Increment sets zero flag on wrap to zero, clears otherwise, one cycle.
// - Increment-and-skip adds one, same destination selection as increment.
// - Zero result discards the fetched next instruction, executing a no-op.
// - Increment-and-skip takes one cycle, or two when skipping.
// - Computed jump loads pc high from pointer low bits, low from accumulator.
// - Computed jump is unconditional, flags unchanged, two cycles.
module mib_core (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     instr_valid_in,
  input  wire mib_pkg::mib_instr_t      instr_in,
  input  wire logic [7:0]               reg_rdata_in,
  input  wire logic [7:0]               table_high_pointer_in,
  output logic      [6:0]               reg_raddr_out,
  output mib_pkg::mib_wr_t              reg_wr_out,
  output logic      [7:0]               accumulator_out,
  output logic      [10:0]              program_counter_out,
  output logic                          global_interrupt_enable_out,
  output logic                          zero_flag_out,
  output logic                          ready_out,
  output logic                          discard_out
);
  mib_pkg::mib_state_t state_q, state_d;
  logic [7:0]          accum_q, accum_d;
  logic [10:0]         pc_q, pc_d;
  logic                int_en_q, int_en_d;
  logic                ready_q, ready_d;
  logic                z_q, z_d;
  mib_pkg::mib_wr_t    wr_q, wr_d;
  logic                disc_q, disc_d;
  logic [7:0]          sum;
  logic                sum_zero;
  logic                take;

  mib_inc #(.W(8)) u_inc (
    .val_in   (reg_rdata_in),
    .sum_out  (sum),
    .zero_out (sum_zero)
  );

  assign take          = instr_valid_in && (state_q == mib_pkg::MIB_EXEC);
  assign reg_raddr_out = instr_in.addr;

  always_comb begin
    state_d  = state_q;
    accum_d  = accum_q;
    pc_d     = pc_q;
    int_en_d = int_en_q;
    z_d     = z_q;
    wr_d    = '0;
    disc_d  = 1'b0;
    case (state_q)
      mib_pkg::MIB_EXEC: begin
        if (take) begin
          pc_d = pc_q + 11'h001;
          case (instr_in.op)
            mib_pkg::OP_INT_ON: begin
              int_en_d = 1'b1;
            end
            mib_pkg::OP_INC, mib_pkg::OP_INCSZ: begin
              if (instr_in.dest == mib_pkg::DEST_ACCUM) begin
                accum_d = sum;
              end else begin
                wr_d.en   = 1'b1;
                wr_d.addr = instr_in.addr;
                wr_d.data = sum;
              end
              if (instr_in.op == mib_pkg::OP_INC) begin
                z_d = sum_zero;
              end else if (sum_zero) begin
                state_d = mib_pkg::MIB_SKIP;
                disc_d  = 1'b1;
              end
            end
            mib_pkg::OP_JUMP: begin
              pc_d    = {table_high_pointer_in[2:0], accum_q};
              state_d = mib_pkg::MIB_JUMP2;
            end
            default: begin
            end
          endcase
        end
      end
      mib_pkg::MIB_SKIP: begin
        pc_d    = pc_q + 11'h001;
        state_d = mib_pkg::MIB_EXEC;
      end
      mib_pkg::MIB_JUMP2: begin
        state_d = mib_pkg::MIB_EXEC;
      end
      default: begin
        state_d = mib_pkg::MIB_EXEC;
      end
    endcase
    ready_d = (state_d == mib_pkg::MIB_EXEC);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= mib_pkg::MIB_EXEC;
      accum_q  <= mib_pkg::ACCUM_RST;
      pc_q     <= mib_pkg::PC_RST;
      int_en_q <= mib_pkg::INT_EN_RST;
      z_q      <= mib_pkg::ZERO_RST;
      wr_q     <= '0;
      disc_q   <= 1'b0;
      ready_q  <= 1'b1;
    end else begin
      state_q  <= state_d;
      accum_q  <= accum_d;
      pc_q     <= pc_d;
      int_en_q <= int_en_d;
      z_q      <= z_d;
      wr_q     <= wr_d;
      disc_q   <= disc_d;
      ready_q  <= ready_d;
    end
  end

  assign accumulator_out             = accum_q;
  assign program_counter_out         = pc_q;
  assign global_interrupt_enable_out = int_en_q;
  assign zero_flag_out               = z_q;
  assign reg_wr_out                  = wr_q;
  assign discard_out                 = disc_q;
  assign ready_out                   = ready_q;

  a_int_enable_set: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INT_ON |=> int_en_q && $stable(z_q) && ready_q)
    else $error("enable interrupts did not set enable bit");

  a_inc_to_accum: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INC && !instr_in.dest |=> accum_q == $past(sum) && !wr_q.en)
    else $error("increment to accumulator wrong");

  a_inc_zero_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INC |=> z_q == ($past(sum) == 8'h00) && ready_q)
    else $error("increment zero flag wrong");

  a_incsz_dest_reg: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && instr_in.dest |=> wr_q.en && wr_q.data == $past(sum))
    else $error("increment skip write back wrong");

  a_skip_discards: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && sum_zero |=> discard_out ##1 !discard_out && ready_q)
    else $error("skip did not discard next instruction");

  a_skip_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && !sum_zero |=> ready_q && !discard_out)
    else $error("no skip should take one cycle");

  a_jump_pc_load: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_JUMP |=> pc_q == {$past(table_high_pointer_in[2:0]), $past(accum_q)})
    else $error("computed jump target wrong");

  a_jump_two_cyc: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_JUMP |=> !ready_q && $stable(z_q) ##1 ready_q)
    else $error("computed jump timing or flags wrong");

  a_incsz_keeps_z: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ |=> $stable(z_q))
    else $error("increment skip changed zero flag");

  a_write_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INC && instr_in.dest |=> wr_q.addr == $past(instr_in.addr))
    else $error("write address wrong");

  a_int_enable_held: assert property (@(posedge clk_in) disable iff (rst_in)
    int_en_q |=> int_en_q)
    else $error("interrupt enable bit was cleared");

  a_int_on_no_data: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INT_ON |=> $stable(accum_q) && !wr_q.en && !discard_out)
    else $error("enable interrupts changed data path");

  a_inc_to_reg: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INC && instr_in.dest |=> wr_q.en && wr_q.data == $past(sum) && $stable(accum_q))
    else $error("increment write back wrong");

  a_inc_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INC |=> ready_q && !discard_out)
    else $error("increment took more than one cycle");

  a_incsz_to_accum: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && !instr_in.dest |=> accum_q == $past(sum) && !wr_q.en)
    else $error("increment skip to accumulator wrong");

  a_skip_ignores_next: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == mib_pkg::MIB_SKIP |=> $stable(accum_q) && $stable(z_q) && $stable(int_en_q) && !wr_q.en)
    else $error("discarded instruction had an effect");

  a_skip_pc_step: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == mib_pkg::MIB_SKIP |=> pc_q == $past(pc_q) + 11'h001)
    else $error("skip cycle did not advance program counter");

  a_skip_ready_low: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && sum_zero |=> !ready_q)
    else $error("skip did not hold ready low");

  a_busy_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    !ready_q |=> !wr_q.en && !discard_out)
    else $error("busy cycle produced a write or discard");

  a_incsz_pc_step: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && !sum_zero |=> pc_q == $past(pc_q) + 11'h001)
    else $error("no skip program counter step wrong");

  a_jump_keeps_pc: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == mib_pkg::MIB_JUMP2 |=> $stable(pc_q) && $stable(z_q))
    else $error("jump second cycle changed pc or flags");

  a_jump_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_JUMP |=> !wr_q.en && $stable(accum_q))
    else $error("computed jump changed data path");

  a_incsz_wr_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    take && instr_in.op == mib_pkg::OP_INCSZ && instr_in.dest |=> wr_q.addr == $past(instr_in.addr))
    else $error("increment skip write address wrong");
endmodule : mib_core

// ### hdl/mib_inc.sv
// Purpose: Eight-bit incrementer with zero detect
// Assumes: Pure combinational
// Notes:   Result wraps at 8 bits
`timescale 1ns/1ps
module mib_inc #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] val_in,
  output logic      [W-1:0] sum_out,
  output logic              zero_out
);
  always_comb begin
    sum_out  = val_in + {{(W-1){1'b0}}, 1'b1};
    zero_out = (sum_out == '0);
  end
endmodule : mib_inc

// ### hdl/mib_pkg.sv
// Purpose: Shared constants and types for the increment and branch execute block
// Assumes: Single 25 MHz clock, synchronous active-high reset
// Notes:   Opcode encodings are local to this block
package mib_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          PC_W         = 11;
  localparam int          PTR_W        = 3;
  localparam logic [2:0]  OP_NONE      = 3'h0;
  localparam logic [2:0]  OP_INT_ON    = 3'h1;
  localparam logic [2:0]  OP_INC       = 3'h2;
  localparam logic [2:0]  OP_INCSZ     = 3'h3;
  localparam logic [2:0]  OP_JUMP      = 3'h4;
  localparam logic        DEST_ACCUM   = 1'b0;
  localparam logic        DEST_REG     = 1'b1;
  localparam logic [7:0]  ACCUM_RST    = 8'h00;
  localparam logic [10:0] PC_RST       = 11'h000;
  localparam logic        INT_EN_RST   = 1'b0;
  localparam logic        ZERO_RST     = 1'b0;

  typedef enum logic [1:0] {
    MIB_EXEC  = 2'b00,
    MIB_SKIP  = 2'b01,
    MIB_JUMP2 = 2'b10
  } mib_state_t;

  typedef struct packed {
    logic [2:0] op;
    logic [6:0] addr;
    logic       dest;
  } mib_instr_t;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } mib_wr_t;
endpackage : mib_pkg
